// [fault_snap_pkg.sv]
// Package for the fault snapshot and configuration store block.
// Assumes a single 20 MHz clock domain and a command decoder upstream.
package fault_snap_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned SNAP_BYTES      = 22;
    localparam int unsigned CFG_WORDS       = 8;
    // Flash programming time in microseconds
    localparam int unsigned FLASH_MIN_US    = 700;
    localparam int unsigned FLASH_MAX_US    = 1400;
    // Neither figure is rounded; both convert exactly at 20 MHz
    localparam int unsigned FLASH_MIN_CYC   = (FLASH_MIN_US * (CLK_HZ / 1_000_000) + 0) ;
    localparam int unsigned FLASH_MAX_CYC   = (FLASH_MAX_US * (CLK_HZ / 1_000_000));
    localparam int unsigned SNAP_EN_BIT     = 1;
    // Monitor words in the snapshot, and the byte that holds the option word
    localparam int unsigned MON_WORDS       = 6;
    localparam int unsigned OPT_BYTE        = 12;
    localparam logic [7:0]  CTL_LOAD_FROM_NV = 8'h01;
    localparam logic [7:0]  CTL_SAVE_TO_NV   = 8'h02;
    localparam logic [7:0]  OPT_RESET        = 8'h00;
    localparam logic [1:0]  LEVEL_RESET      = 2'h0;
    typedef enum logic [1:0] {RESP_IGNORE, RESP_RETRY, RESP_SHUTDOWN} fault_resp_t;
    typedef enum {ST_INIT, ST_IDLE, ST_PROG, ST_LOAD} nv_state_t;
endpackage

// [fault_snap_nv.sv]
// Fault snapshot capture, snapshot flash store and configuration stores.
// Assumes the PMBus decoder presents commands as one-cycle strobes on sys_clk.
`timescale 1ns/10ps

module fault_snap_nv (
    input  wire logic        sys_clk,        // 20 MHz clock
    input  wire logic        sys_rst,        // Async reset, active high
    input  wire logic [7:0]  option_word,    // General option word
    input  wire logic        conv_enabled,   // Power conversion running
    input  wire logic        fault_event,    // Fault threshold exceeded, pulse
    input  wire logic [1:0]  fault_resp,     // Response configured for that fault
    input  wire logic        ctl_wr,         // Snapshot control write strobe
    input  wire logic [7:0]  ctl_data,       // Snapshot control value
    input  wire logic        snap_rd,        // Snapshot readout byte request
    input  wire logic [4:0]  snap_idx,       // Byte index in the block
    output logic      [7:0]  snap_data,      // Snapshot byte read out
    input  wire logic [15:0] mon_vin,        // Input voltage reading
    input  wire logic [15:0] mon_vout,       // Output voltage reading
    input  wire logic [15:0] mon_iout,       // Output current reading
    input  wire logic [15:0] mon_temp,       // Internal temperature reading
    input  wire logic [15:0] mon_freq,       // Switching frequency reading
    input  wire logic [15:0] mon_duty,       // Duty cycle reading
    input  wire logic [2:0]  mon_sel,        // Monitor quantity select
    output logic      [15:0] mon_data,       // Monitor readout
    input  wire logic        cfg_wr,         // Working setting write
    input  wire logic [2:0]  cfg_addr,       // Setting index
    input  wire logic [7:0]  cfg_wdata,      // Setting value
    input  wire logic        store_user,     // Save settings to user store
    input  wire logic        restore_user,   // Restore from user store
    input  wire logic        restore_default,// Revert working settings to factory
    input  wire logic [1:0]  user_level,     // Level made available to user
    input  wire logic [1:0]  need_level,     // Level required to restore
    output logic      [7:0]  cfg_rdata,      // Working setting read
    output logic             nv_busy,        // Flash programming in progress
    output logic             ready           // Initialization complete
);
    // ==========================================================
    // Storage
    logic [7:0] snap_ram_q [fault_snap_pkg::SNAP_BYTES];
    logic [7:0] snap_nv_q  [fault_snap_pkg::SNAP_BYTES];
    logic [7:0] cfg_q      [fault_snap_pkg::CFG_WORDS];
    logic [7:0] user_q     [fault_snap_pkg::CFG_WORDS];
    logic [7:0] dflt       [fault_snap_pkg::CFG_WORDS];
    logic [7:0] mon_bytes  [fault_snap_pkg::SNAP_BYTES];
    logic [7:0] snap_ram_d [fault_snap_pkg::SNAP_BYTES];
    logic [7:0] snap_nv_d  [fault_snap_pkg::SNAP_BYTES];
    logic [7:0] cfg_d      [fault_snap_pkg::CFG_WORDS];
    logic [7:0] user_d     [fault_snap_pkg::CFG_WORDS];
    // Monitor words in snapshot order: vin, vout, iout, temp, freq, duty
    logic [15:0] mon_word  [fault_snap_pkg::MON_WORDS];

    fault_snap_pkg::nv_state_t state_q, state_d;
    logic [15:0] cnt_q, cnt_d;
    logic        snap_en;
    logic        save_req;
    logic        restore_ok;
    logic        held_q, held_d;
    logic        save_start;
    logic        capture;
    logic        prog_done;
    logic [7:0]  snap_data_d;
    logic [15:0] mon_data_d;
    logic [7:0]  cfg_rdata_d;

    assign snap_en = option_word[fault_snap_pkg::SNAP_EN_BIT];
    // Only a shutdown response saves; retry saves nothing
    assign save_req = (snap_en && fault_event &&
                       fault_snap_pkg::fault_resp_t'(fault_resp) == fault_snap_pkg::RESP_SHUTDOWN) ||
                      (snap_en && ctl_wr && ctl_data == fault_snap_pkg::CTL_SAVE_TO_NV && !conv_enabled);
    assign restore_ok = user_level >= need_level;

    // Snapshot content: monitor words low byte first, then option word, zero padded
    always_comb begin
        mon_word[0] = mon_vin;
        mon_word[1] = mon_vout;
        mon_word[2] = mon_iout;
        mon_word[3] = mon_temp;
        mon_word[4] = mon_freq;
        mon_word[5] = mon_duty;
        for (int i = 0; i < fault_snap_pkg::SNAP_BYTES; i++) begin
            mon_bytes[i] = 8'h00;
        end
        for (int w = 0; w < fault_snap_pkg::MON_WORDS; w++) begin
            {mon_bytes[2 * w + 1], mon_bytes[2 * w]} = mon_word[w];
        end
        mon_bytes[fault_snap_pkg::OPT_BYTE] = option_word;
    end

    // Factory defaults; arbitrary neutral values
    genvar g;
    generate
        for (g = 0; g < fault_snap_pkg::CFG_WORDS; g++) begin : g_dflt
            assign dflt[g] = 8'(g);
        end
    endgenerate

    // ==========================================================
    // Sequencer
    // One operation at a time: requests arriving while busy or loading are dropped
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            fault_snap_pkg::ST_INIT: begin
                state_d = fault_snap_pkg::ST_IDLE;
            end
            fault_snap_pkg::ST_IDLE: begin
                if (save_req) begin
                    state_d = fault_snap_pkg::ST_PROG;
                    // Program time sits at the shortest figure; busy always lasts FLASH_MIN_CYC cycles
                    cnt_d   = 16'(fault_snap_pkg::FLASH_MIN_CYC - 1);
                end else if (snap_en && ctl_wr && ctl_data == fault_snap_pkg::CTL_LOAD_FROM_NV) begin
                    state_d = fault_snap_pkg::ST_LOAD;
                end
                // Other control values fall through untouched
            end
            fault_snap_pkg::ST_PROG: begin
                if (cnt_q == 16'h0000) begin
                    state_d = fault_snap_pkg::ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            fault_snap_pkg::ST_LOAD: begin
                state_d = fault_snap_pkg::ST_IDLE;
            end
            default: state_d = fault_snap_pkg::ST_IDLE;
        endcase
    end

    // Reset parks the sequencer in init so stored settings load first
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= fault_snap_pkg::ST_INIT;
            cnt_q   <= 16'h0000;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Busy is decoded from state, so it rises the cycle after the request
    assign nv_busy = (state_q == fault_snap_pkg::ST_PROG);
    assign ready   = (state_q != fault_snap_pkg::ST_INIT);

    // ==========================================================
    // Snapshot RAM and flash image
    // Capture is frozen while programming so the image is coherent.
    // A loaded image must stay put for the host, so live capture
    // waits until a save begins or capture is switched off.
    always_comb begin
        held_d = held_q;
        // Set wins if a load and a capture switch-off coincide
        if (state_q == fault_snap_pkg::ST_LOAD) begin
            held_d = 1'b1;
        end else if (!snap_en || save_start) begin
            held_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            held_q <= 1'b0;
        end else begin
            held_q <= held_d;
        end
    end

    // Live capture stops once a save is requested so the saved image matches the fault
    assign save_start = (state_q == fault_snap_pkg::ST_IDLE) && save_req;
    assign capture    = snap_en && !held_q && !save_req &&
                        (state_q == fault_snap_pkg::ST_IDLE);
    assign prog_done  = (state_q == fault_snap_pkg::ST_PROG) && (cnt_q == 16'h0000);

    // The flash image is only a register here, so it does not survive reset
    generate
        for (g = 0; g < fault_snap_pkg::SNAP_BYTES; g++) begin : g_snap
            always_comb begin
                snap_ram_d[g] = snap_ram_q[g];
                snap_nv_d[g]  = snap_nv_q[g];
                if (state_q == fault_snap_pkg::ST_LOAD) begin
                    snap_ram_d[g] = snap_nv_q[g];
                end else if (capture) begin
                    snap_ram_d[g] = mon_bytes[g];
                end
                if (prog_done) begin
                    snap_nv_d[g] = snap_ram_q[g];
                end
            end

            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    snap_ram_q[g] <= 8'h00;
                    snap_nv_q[g]  <= 8'h00;
                end else begin
                    snap_ram_q[g] <= snap_ram_d[g];
                    snap_nv_q[g]  <= snap_nv_d[g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Snapshot readout, served in any state
    // The last byte stays on the port until the next request
    always_comb begin
        snap_data_d = snap_data;
        if (snap_rd) begin
            snap_data_d = (snap_idx < 5'(fault_snap_pkg::SNAP_BYTES)) ? snap_ram_q[snap_idx] : 8'h00;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            snap_data <= 8'h00;
        end else begin
            snap_data <= snap_data_d;
        end
    end

    // ==========================================================
    // Monitor readout
    // Unused select codes read zero rather than a stale word
    always_comb begin
        mon_data_d = 16'h0000;
        if (mon_sel < 3'(fault_snap_pkg::MON_WORDS)) begin
            mon_data_d = mon_word[mon_sel];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mon_data <= 16'h0000;
        end else begin
            mon_data <= mon_data_d;
        end
    end

    // ==========================================================
    // Configuration stores
    // Init leaves working settings at the user store, which starts at defaults
    generate
        for (g = 0; g < fault_snap_pkg::CFG_WORDS; g++) begin : g_cfg
            // Default restore wins over user restore, and either over a plain write
            always_comb begin
                cfg_d[g]  = cfg_q[g];
                user_d[g] = user_q[g];
                if (state_q == fault_snap_pkg::ST_INIT) begin
                    cfg_d[g]  = dflt[g];
                    user_d[g] = dflt[g];
                end else if (restore_default && restore_ok) begin
                    cfg_d[g] = dflt[g];
                end else if (restore_user && restore_ok) begin
                    cfg_d[g] = user_q[g];
                end else if (cfg_wr && cfg_addr == 3'(g)) begin
                    cfg_d[g] = cfg_wdata;
                end
                if (store_user && state_q != fault_snap_pkg::ST_INIT) begin
                    user_d[g] = cfg_q[g];
                end
            end

            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cfg_q[g]  <= 8'h00;
                    user_q[g] <= 8'h00;
                end else begin
                    cfg_q[g]  <= cfg_d[g];
                    user_q[g] <= user_d[g];
                end
            end
        end
    endgenerate

    // Setting read port, one cycle behind the address
    always_comb begin
        cfg_rdata_d = cfg_q[cfg_addr];
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_rdata <= 8'h00;
        end else begin
            cfg_rdata <= cfg_rdata_d;
        end
    end
endmodule // fault_snap_nv

// [host_rd.sv]
// Host model: reads the snapshot block one byte per request.
// Assumes snap_data answers one cycle after snap_rd.
`timescale 1ns/10ps
module host_rd (
    input  wire logic       sys_clk,   // Clock
    input  wire logic       go,        // Start a block read
    output logic            snap_rd,   // Byte request
    output logic      [4:0] snap_idx,  // Byte index
    input  wire logic [7:0] snap_data, // Byte returned
    output logic      [7:0] blk [22],  // Bytes read
    output logic            done       // Block complete
);
    // ====================
    // Block read of 22 bytes
    initial begin
        {snap_rd, snap_idx, done} = 7'h00;
        forever begin
            @(posedge sys_clk iff go);
            done = 1'b0;
            for (int i = 0; i < 22; i++) begin
                @(negedge sys_clk);
                {snap_rd, snap_idx} = {1'b1, 5'(i)};
                @(negedge sys_clk);
                // Released index shows its inverse so a stale value is not reused
                {snap_rd, snap_idx} = {1'b0, ~5'(i)};
                blk[i] = snap_data;
            end
            done = 1'b1;
        end
    end
endmodule // host_rd

// [fault_snap_properties.sv]
// Checker for the snapshot store, bound to its ports.
// Assumes one clock; sys_rst disables every check.
`timescale 1ns/10ps
module fault_snap_properties (
    input wire logic        sys_clk,      // Clock
    input wire logic        sys_rst,      // Reset
    input wire logic [7:0]  option_word,  // Option word
    input wire logic        conv_enabled, // Conversion on
    input wire logic        fault_event,  // Fault pulse
    input wire logic [1:0]  fault_resp,   // Fault response
    input wire logic        ctl_wr,       // Control strobe
    input wire logic [7:0]  ctl_data,     // Control value
    input wire logic [15:0] mon_vin,      // Input voltage
    input wire logic [2:0]  mon_sel,      // Monitor select
    input wire logic [15:0] mon_data,     // Monitor out
    input wire logic        nv_busy,      // Program running
    input wire logic        ready         // Init done
);
    int unsigned len_q;
    logic        ok;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ====================
    // Helpers
    // Program length is judged when busy drops, too long for a repetition
    always_ff @(posedge sys_clk or posedge sys_rst)
        if (sys_rst) len_q <= 0;
        else len_q <= nv_busy ? len_q + 1 : 0;
    assign ok = ready && !nv_busy && option_word[1];
    // ====================
    // Properties
    save_start_a: assert property (ok && !$past(ctl_wr) && ctl_wr && ctl_data == 8'h02 && !conv_enabled |=> nv_busy)
        else $error("save not started");
    conv_block_a: assert property (!nv_busy && ctl_wr && ctl_data == 8'h02 && conv_enabled && !fault_event |=> !nv_busy)
        else $error("save while converting");
    bad_value_a: assert property (!nv_busy && ctl_wr && ctl_data > 8'h02 && !fault_event |=> !nv_busy)
        else $error("bad control value acted on");
    retry_skip_a: assert property (!nv_busy && fault_event && fault_resp != 2'h2 && !ctl_wr |=> !nv_busy)
        else $error("retry fault programmed");
    fault_save_a: assert property (ok && !$past(ctl_wr) && fault_event && fault_resp == 2'h2 |=> nv_busy)
        else $error("shutdown fault not saved");
    capture_off_a: assert property (!option_word[1] && !nv_busy |=> !nv_busy)
        else $error("program with capture off");
    prog_time_a: assert property ($fell(nv_busy) |-> len_q == fault_snap_pkg::FLASH_MIN_CYC)
        else $error("program length wrong");
    mon_vin_a: assert property (mon_sel == 3'h0 |=> mon_data == $past(mon_vin))
        else $error("input voltage readout wrong");
    cover property ($fell(nv_busy));
    cover property (fault_event && fault_resp == 2'h2);
    cover property (ctl_wr && conv_enabled);
    cover property (ok && ctl_wr && ctl_data == 8'h01);
endmodule // fault_snap_properties
bind fault_snap_nv fault_snap_properties chk (.sys_clk, .sys_rst, .option_word, .conv_enabled, .fault_event,
    .fault_resp, .ctl_wr, .ctl_data, .mon_vin, .mon_sel, .mon_data, .nv_busy, .ready);

// [tb.sv]
// Testbench: drives the snapshot store and the host model, judges the ports.
// Assumes the default program time of the package.
`timescale 1ns/10ps
module tb;
    logic        sys_clk, sys_rst, conv_enabled, fault_event, ctl_wr, cfg_wr, snap_rd;
    logic        store_user, restore_user, restore_default, go, done, nv_busy, ready;
    logic [7:0]  option_word, ctl_data, snap_data, cfg_wdata, cfg_rdata, e;
    logic [1:0]  fault_resp, user_level, need_level;
    logic [2:0]  mon_sel, cfg_addr;
    logic [4:0]  snap_idx;
    logic [15:0] mon [6];
    logic [15:0] mon_data;
    logic [7:0]  blk [22];
    int          err_total, comparisons, n;
    fault_snap_nv uut (.sys_clk, .sys_rst, .option_word, .conv_enabled, .fault_event, .fault_resp, .ctl_wr,
        .ctl_data, .snap_rd, .snap_idx, .snap_data, .mon_vin(mon[0]), .mon_vout(mon[1]), .mon_iout(mon[2]),
        .mon_temp(mon[3]), .mon_freq(mon[4]), .mon_duty(mon[5]), .mon_sel, .mon_data, .cfg_wr, .cfg_addr,
        .cfg_wdata, .store_user, .restore_user, .restore_default, .user_level, .need_level, .cfg_rdata,
        .nv_busy, .ready);
    host_rd host (.sys_clk, .go, .snap_rd, .snap_idx, .snap_data, .blk, .done);
    // ====================
    // Shared tasks
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask
    task automatic wait_hi(string what, ref logic s);
        for (int k = 0; k < 200 && s !== 1'b1; k++) @(negedge sys_clk);
        if (s !== 1'b1) begin
            chk(what, 16'h1, 16'(s));
            summarize();
        end
    endtask
    task automatic try_op(logic [7:0] opt, logic conv, logic [7:0] val, logic [1:0] resp, logic flt, logic exp);
        {option_word, conv_enabled, ctl_data, fault_resp} = {opt, conv, val, resp};
        if (flt) pulse(fault_event);
        else pulse(ctl_wr);
        chk("busy", 16'(exp), 16'(nv_busy));
        // Busy is sampled each falling edge, so the count is whole cycles
        for (n = 0; exp && nv_busy === 1'b1 && n < 20000; n++) @(negedge sys_clk);
        if (exp) chk("program cycles", 16'(fault_snap_pkg::FLASH_MIN_CYC), 16'(n));
        if (n == 20000) summarize();
    endtask
    // ====================
    // Scenarios
    task automatic t_mon();
        for (int i = 0; i < 7; i++) begin
            mon_sel = 3'(i);
            @(negedge sys_clk);
            chk("mon_data", i < 6 ? mon[i] : 16'h0, mon_data);
        end
    endtask
    task automatic t_snap(logic [15:0] m [6]);
        pulse(go);
        wait_hi("done", done);
        for (int i = 0; i < 22; i++) begin
            e = i < 12 ? (i[0] ? m[i/2][15:8] : m[i/2][7:0]) : (i == 12 ? option_word : 8'h00);
            chk("snapshot byte", 16'(e), 16'(blk[i]));
        end
    endtask
    // Saved image must come back after a load although the monitors moved on
    task automatic t_load();
        logic [15:0] old [6];
        old = mon;
        mon = '{16'h4321, 16'h5ca0, 16'h017e, 16'h4900, 16'h0123, 16'h8c00};
        repeat (2) @(negedge sys_clk);
        {ctl_data, conv_enabled} = {8'h01, 1'b1};
        pulse(ctl_wr);
        t_snap(old);
    endtask
    task automatic t_cfg();
        {cfg_addr, cfg_wdata, need_level, user_level} = {3'h3, 8'h5a, 2'h1, 2'h0};
        pulse(cfg_wr);
        pulse(store_user);
        cfg_wdata = 8'h11;
        pulse(cfg_wr);
        pulse(restore_user);
        pulse(restore_default);
        @(negedge sys_clk);
        chk("setting kept", 16'h11, 16'(cfg_rdata));
        user_level = 2'h2;
        pulse(restore_user);
        @(negedge sys_clk);
        chk("user store", 16'h5a, 16'(cfg_rdata));
        pulse(restore_default);
        @(negedge sys_clk);
        chk("default store", 16'h3, 16'(cfg_rdata));
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        {sys_rst, conv_enabled, fault_event, ctl_wr, cfg_wr, store_user, restore_user, restore_default, go} = 9'h100;
        {option_word, ctl_data, cfg_wdata, fault_resp, user_level, need_level, mon_sel, cfg_addr} = '0;
        mon = '{16'h1234, 16'h0a5c, 16'h7e01, 16'h0049, 16'h3210, 16'h00c8};
        {err_total, comparisons} = '0;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        wait_hi("ready", ready);
        cfg_addr = 3'h5;
        @(negedge sys_clk);
        chk("default setting", 16'h5, 16'(cfg_rdata));
        t_mon();
        option_word = 8'h02;
        repeat (2) @(negedge sys_clk);
        t_snap(mon);
        try_op(8'h02, 1'b1, 8'h02, 2'h0, 1'b0, 1'b0);
        try_op(8'h00, 1'b0, 8'h02, 2'h0, 1'b0, 1'b0);
        foreach (blk[i]) if (i < 3) try_op(8'h02, 1'b0, i == 0 ? 8'h00 : 8'(i * 126 + 3), 2'h0, 1'b0, 1'b0);
        try_op(8'h02, 1'b0, 8'h00, 2'h0, 1'b1, 1'b0);
        try_op(8'h02, 1'b0, 8'h00, 2'h1, 1'b1, 1'b0);
        try_op(8'h02, 1'b0, 8'h02, 2'h0, 1'b0, 1'b1);
        try_op(8'h02, 1'b0, 8'h00, 2'h2, 1'b1, 1'b1);
        t_snap(mon);
        t_load();
        t_cfg();
        summarize();
    end
endmodule // tb
